// [src/pes_consts.vh]
// constants for the precise event sampler
`ifndef PES_CONSTS_VH
`define PES_CONSTS_VH
`define PES_IP_W 32
`define PES_REG_W 32
`define PES_NREGS 16
`define PES_LAT_W 16
`define PES_SRC_W 4
`define PES_CNT_W 32
`define PES_STALL_W 32
`define PES_THR_LO 0
`define PES_THR_HI 15
`define PES_FIFO_DEPTH 16
`define PES_FIFO_AW 4
`define PES_CLASS_MEM 1'b0
`define PES_CLASS_EXEC 1'b1
`define PES_RST_CNT 32'h00000000
`endif

// [src/pes_fifo.v]
// synchronous fifo holding sample records
`timescale 1ns/1ps
module pes_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire full
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;
  assign full = (count == DEPTH);
  assign in_ready = !full;
  assign out_valid = (count != 0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end
endmodule

// [src/pes_sampler.v]
// precise event sampler: arm on overflow, capture at retirement, buffer
// What this block does
// - counter overflow arms capture, not captures
// - next armed event records sample into the buffer
// - record holds register state and pointer
// - stored pointer is the next instruction
// - events evaluated only at retirement
// - records buffered; interrupt only when buffer full
// - core stall count sums both threads
// - per-thread stall count for ports 0,1,5
// - retirement stall event per thread, precise
// - events split into memory and execution classes
// - latency records carry latency and source
// - latency counts only above threshold bits 15:0
`timescale 1ns/1ps
`include "pes_consts.vh"
module pes_sampler (
  input wire clk,
  input wire rst,
  input wire [31:0] counter_reload,
  input wire event_class,
  input wire latency_mode,
  input wire [31:0] load_latency_threshold,
  input wire retire_valid,
  input wire retire_thread,
  input wire retire_is_mem,
  input wire retire_event,
  input wire retire_stall,
  input wire [`PES_IP_W-1:0] retire_next_ip,
  input wire [`PES_REG_W*`PES_NREGS-1:0] retire_regs,
  input wire [`PES_LAT_W-1:0] retire_latency,
  input wire [`PES_SRC_W-1:0] retire_source,
  input wire [1:0] exec_stall_thread,
  input wire [1:0] alu_port_stall_thread,
  input wire rec_ready,
  output reg rec_valid,
  output reg [`PES_IP_W-1:0] rec_ip,
  output reg [`PES_REG_W*`PES_NREGS-1:0] rec_regs,
  output reg [`PES_LAT_W-1:0] rec_latency,
  output reg [`PES_SRC_W-1:0] rec_source,
  output reg rec_thread,
  output reg monitor_interrupt,
  output reg armed,
  output reg [`PES_CNT_W-1:0] event_count,
  output reg [`PES_STALL_W-1:0] core_exec_stall_count,
  output reg [`PES_STALL_W-1:0] thread_alu_port_stall_count0,
  output reg [`PES_STALL_W-1:0] thread_alu_port_stall_count1,
  output reg [`PES_STALL_W-1:0] retire_stall_count0,
  output reg [`PES_STALL_W-1:0] retire_stall_count1,
  output reg overflow_seen
);
  // ======================================================================
  // record layout and arm states
  localparam REC_W = `PES_IP_W + `PES_REG_W * `PES_NREGS + `PES_LAT_W +
    `PES_SRC_W + 1;
  localparam ST_IDLE = 1'b0;
  localparam ST_ARMED = 1'b1;
  localparam [`PES_CNT_W-1:0] CNT_TOP = {`PES_CNT_W{1'b1}};
  localparam [`PES_CNT_W-1:0] CNT_ONE = 32'h00000001;
  localparam [`PES_STALL_W-1:0] STALL_ZERO = `PES_RST_CNT;

  // ======================================================================
  // internal nets
  // all inputs come from core logic on this clock, so no synchronisers
  wire class_ok;
  wire above_threshold;
  wire qualify;
  wire at_top;
  wire capture_req;
  wire [`PES_LAT_W-1:0] lat_field;
  wire [`PES_SRC_W-1:0] src_field;
  wire [REC_W-1:0] rec_word;
  wire fifo_in_ready;
  wire [REC_W-1:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire fifo_full;
  wire [1:0] retire_stall_hit;
  wire [`PES_STALL_W-1:0] core_stall_inc;
  reg next_armed;
  reg [`PES_CNT_W-1:0] next_event_count;
  reg next_overflow_seen;

  // ======================================================================
  // event qualification
  // only the retire port is looked at, so speculative work never counts
  assign class_ok = (event_class == `PES_CLASS_EXEC) ||
    retire_is_mem;
  assign above_threshold = retire_latency >
    load_latency_threshold[`PES_THR_HI:`PES_THR_LO];
  assign qualify = retire_valid && retire_event && class_ok &&
    (!latency_mode || above_threshold);
  assign at_top = (event_count == CNT_TOP);
  assign capture_req = (armed == ST_ARMED) && qualify;

  // ======================================================================
  // record word
  // latency and source only mean something in latency sampling
  assign lat_field = latency_mode ? retire_latency :
    {`PES_LAT_W{1'b0}};
  assign src_field = latency_mode ? retire_source :
    {`PES_SRC_W{1'b0}};
  // the retire port already gives the pointer past the finished instruction
  assign rec_word = {retire_thread, src_field, lat_field,
    retire_regs,
    retire_next_ip};

  // ======================================================================
  // per thread retirement stall hits
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_thread
      assign retire_stall_hit[gi] = retire_valid && retire_stall &&
        (retire_thread == (gi == 1));
    end
  endgenerate

  // core stall adds one per stalled thread, so both threads are summed
  assign core_stall_inc = {{(`PES_STALL_W-1){1'b0}}, exec_stall_thread[0]} +
    {{(`PES_STALL_W-1){1'b0}}, exec_stall_thread[1]};

  // ======================================================================
  // arm state
  // overflow only arms; the record waits for the next qualifying event
  always @*
  begin
    next_armed = armed;
    case (armed)
      ST_IDLE:
      begin
        if (qualify && at_top)
          next_armed = ST_ARMED;
      end
      ST_ARMED:
      begin
        if (capture_req && fifo_in_ready)
          next_armed = ST_IDLE;
        // a new overflow in the capture cycle re-arms: set wins
        if (qualify && at_top)
          next_armed = ST_ARMED;
      end
      default:
      begin
        next_armed = ST_IDLE;
      end
    endcase
  end

  // ======================================================================
  // event counter
  // overflow reloads the sample-after value instead of wrapping to zero
  always @*
  begin
    next_event_count = event_count;
    if (qualify)
    begin
      if (at_top)
        next_event_count = counter_reload;
      else
        next_event_count = event_count + CNT_ONE;
    end
  end

  always @*
  begin
    next_overflow_seen = overflow_seen;
    if (qualify && at_top)
      next_overflow_seen = 1'b1;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      armed <= ST_IDLE;
      event_count <= counter_reload;
      overflow_seen <= 1'b0;
      monitor_interrupt <= 1'b0;
    end
    else
    begin
      armed <= next_armed;
      event_count <= next_event_count;
      overflow_seen <= next_overflow_seen;
      // records pile up quietly; software is only called when full
      monitor_interrupt <= fifo_full;
    end
  end

  // ======================================================================
  // stall counters
  always @(posedge clk)
  begin
    if (rst)
    begin
      core_exec_stall_count <= STALL_ZERO;
      thread_alu_port_stall_count0 <= STALL_ZERO;
      thread_alu_port_stall_count1 <= STALL_ZERO;
      retire_stall_count0 <= STALL_ZERO;
      retire_stall_count1 <= STALL_ZERO;
    end
    else
    begin
      core_exec_stall_count <= core_exec_stall_count +
        core_stall_inc;
      thread_alu_port_stall_count0 <= thread_alu_port_stall_count0 +
        {{(`PES_STALL_W-1){1'b0}}, alu_port_stall_thread[0]};
      thread_alu_port_stall_count1 <= thread_alu_port_stall_count1 +
        {{(`PES_STALL_W-1){1'b0}}, alu_port_stall_thread[1]};
      retire_stall_count0 <= retire_stall_count0 +
        {{(`PES_STALL_W-1){1'b0}}, retire_stall_hit[0]};
      retire_stall_count1 <= retire_stall_count1 +
        {{(`PES_STALL_W-1){1'b0}}, retire_stall_hit[1]};
    end
  end

  // ======================================================================
  // record buffer
  // a capture that meets a full buffer is dropped, not written, and the sampler stays armed
  pes_fifo #(
    .WIDTH(REC_W),
    .DEPTH(`PES_FIFO_DEPTH),
    .AW(`PES_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(rec_word),
    .in_valid(capture_req),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .full(fifo_full)
  );

  // ======================================================================
  // output stage
  // one register slice keeps every record output on a flip-flop
  assign fifo_out_ready = !rec_valid || rec_ready;

  always @(posedge clk)
  begin
    if (rst)
    begin
      rec_valid <= 1'b0;
      rec_ip <= {`PES_IP_W{1'b0}};
      rec_regs <= {(`PES_REG_W*`PES_NREGS){1'b0}};
      rec_latency <= {`PES_LAT_W{1'b0}};
      rec_source <= {`PES_SRC_W{1'b0}};
      rec_thread <= 1'b0;
    end
    else
    begin
      if (fifo_out_ready)
      begin
        rec_valid <= fifo_out_valid;
        if (fifo_out_valid)
        begin
          {rec_thread, rec_source, rec_latency, rec_regs, rec_ip} <=
            fifo_out_data;
        end
      end
    end
  end
endmodule

// [verif/pes_sampler_sva.sv]
// port assertions for the sampler
`timescale 1ns/1ps
module pes_sampler_sva (
  input wire clk,
  input wire rst,
  input wire retire_valid,
  input wire retire_event,
  input wire [31:0] counter_reload,
  input wire [1:0] alu_port_stall_thread,
  input wire [31:0] thread_alu_port_stall_count0,
  input wire overflow_seen,
  input wire latency_mode,
  input wire [31:0] load_latency_threshold,
  input wire [15:0] retire_latency,
  input wire [1:0] exec_stall_thread,
  input wire rec_valid,
  input wire armed,
  input wire [31:0] event_count,
  input wire [31:0] core_exec_stall_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_stall_both_thr:
  assert property (!$past(rst) |-> core_exec_stall_count ==
    $past(core_exec_stall_count) + $countones($past(exec_stall_thread)))
    else $error("core stall sum wrong");
  chk_lat_below:
  assert property (latency_mode && retire_valid &&
    retire_latency <= load_latency_threshold[15:0] |=> $stable(event_count))
    else $error("count moved at or below threshold");
  chk_retire_only:
  assert property (!retire_valid |=> $stable(event_count))
    else $error("count moved without retirement");
  chk_arm_reload:
  assert property ($rose(armed) |-> event_count == $past(counter_reload))
    else $error("armed without overflow reload");
  chk_disarm_evt:
  assert property ($fell(armed) |-> $past(retire_valid && retire_event))
    else $error("disarmed without a retired event");
  chk_ovf_sticky:
  assert property (overflow_seen |=> overflow_seen)
    else $error("overflow flag cleared");
  chk_alu_thr0:
  assert property (!$past(rst) |-> thread_alu_port_stall_count0 ==
    $past(thread_alu_port_stall_count0) + $past(alu_port_stall_thread[0]))
    else $error("thread alu stall count wrong");
  cover property ($rose(rec_valid));
  cover property ($rose(armed));
  cover property (exec_stall_thread == 2'b11);
endmodule
bind pes_sampler pes_sampler_sva u_sva (.*);

// [verif/pes_sampler_tb.sv]
// bench for the sampler
`timescale 1ns/1ps
module pes_sampler_tb;
  reg clk=0,rst=1,event_class=0,latency_mode=0,retire_valid=0,retire_event=0;
  reg retire_thread=0,retire_is_mem=0,retire_stall=0,rec_ready=1;
  reg [31:0] counter_reload=0,load_latency_threshold=10,retire_next_ip=0;
  reg [511:0] retire_regs=0;
  reg [15:0] retire_latency=0;
  reg [3:0] retire_source=0;
  reg [1:0] exec_stall_thread=0,alu_port_stall_thread=0;
  wire [511:0] rec_regs;
  wire [31:0] rec_ip,event_count,core_exec_stall_count,retire_stall_count0,
    retire_stall_count1,thread_alu_port_stall_count0,
    thread_alu_port_stall_count1;
  wire [15:0] rec_latency;
  wire [3:0] rec_source;
  wire rec_valid,rec_thread,monitor_interrupt,armed,overflow_seen;
  integer bad_count=0,n_checks=0,t=0;
  reg [31:0] c;
  pes_sampler dut (.*);
  always #25 clk = ~clk;
  // a stuck run still reaches the verdict
  always @(posedge clk) if (++t == 2000) bad_count++;
  always @(negedge clk) if (t == 2000) tally_and_finish;
  task chk(input [31:0] s, input [31:0] e);
    n_checks++;
    if (s !== e) bad_count++;
    if (s !== e) $display("[ERR] %0t %h %h", $time, s, e);
  endtask
  task tally_and_finish;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_stall;
    c = core_exec_stall_count;
    exec_stall_thread = 2'b11;
    repeat (3) @(negedge clk);
    exec_stall_thread = 2'b01;
    @(negedge clk);
    exec_stall_thread = 0;
    @(negedge clk);
    chk(core_exec_stall_count, c + 7);
  endtask
  task t_alu;
    c = thread_alu_port_stall_count0;
    alu_port_stall_thread = 2'b01;
    repeat (3) @(negedge clk);
    alu_port_stall_thread = 2'b10;
    @(negedge clk);
    alu_port_stall_thread = 0;
    @(negedge clk);
    chk(thread_alu_port_stall_count0, c + 3);
    chk(thread_alu_port_stall_count1, 1);
  endtask
  task t_retstall;
    {retire_valid, retire_stall, retire_thread} = 3'b111;
    repeat (2) @(negedge clk);
    retire_thread = 0;
    @(negedge clk);
    {retire_valid, retire_stall} = 2'b00;
    @(negedge clk);
    chk(retire_stall_count1, 2);
    chk(retire_stall_count0, 1);
  endtask
  task t_thr(input [15:0] lat, input mem, input vld, input [31:0] inc);
    c = event_count;
    {latency_mode, retire_valid, retire_event} = {2'b11, vld};
    retire_valid = vld;
    retire_event = 1;
    retire_is_mem = mem;
    retire_latency = lat;
    @(negedge clk);
    {retire_valid, retire_event} = 2'b00;
    @(negedge clk);
    chk(event_count, c + inc);
  endtask
  task t_reset(input [31:0] reload);
    counter_reload = reload;
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    @(negedge clk);
    chk(event_count, reload);
    chk(armed, 0);
  endtask
  task t_capture;
    latency_mode = 1;
    event_class = 0;
    retire_is_mem = 1;
    retire_latency = 16'h0014;
    retire_source = 4'h5;
    retire_thread = 1;
    retire_next_ip = 32'h00001000;
    retire_regs[31:0] = 32'h00000aaa;
    {retire_valid, retire_event} = 2'b11;
    @(negedge clk);
    chk(armed, 0);
    @(negedge clk);
    chk(armed, 1);
    chk(event_count, 32'hfffffffe);
    retire_next_ip = 32'h00002000;
    retire_regs[31:0] = 32'h00000bbb;
    @(negedge clk);
    chk(armed, 0);
    {retire_valid, retire_event} = 2'b00;
    @(negedge clk);
    chk(rec_valid, 1);
    chk(rec_ip, 32'h00002000);
    chk(rec_regs[31:0], 32'h00000bbb);
    chk(rec_thread, 1);
    chk(rec_latency, 32'h00000014);
    chk(rec_source, 32'h00000005);
    chk(overflow_seen, 1);
    @(negedge clk);
    chk(rec_valid, 0);
    chk(armed, 0);
  endtask
  task t_full;
    event_class = 1;
    latency_mode = 0;
    rec_ready = 0;
    {retire_valid, retire_event} = 2'b11;
    repeat (10) @(negedge clk);
    chk(monitor_interrupt, 0);
    repeat (10) @(negedge clk);
    chk(monitor_interrupt, 1);
    chk(rec_valid, 1);
    {retire_valid, retire_event} = 2'b00;
    rec_ready = 1;
    repeat (20) @(negedge clk);
    chk(monitor_interrupt, 0);
    chk(rec_valid, 0);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 0;
    @(negedge clk);
    t_retstall;
    t_stall;
    t_alu;
    t_thr(16'h000a, 1, 1, 0);
    t_thr(16'h000b, 1, 1, 1);
    t_thr(16'h000b, 0, 1, 0);
    t_thr(16'h000b, 1, 0, 0);
    t_reset(32'hfffffffe);
    t_capture;
    t_reset(32'hffffffff);
    t_full;
    tally_and_finish;
  end
endmodule
